//--- bench/cip_pins_model.sv
module cip_pins_model (
    // block side of the pins
    input  wire logic [26:0] i_out,
    input  wire logic [26:0] i_oe,
    // level the far logic puts on an undriven pin
    input  wire logic [26:0] i_ext,
    // resolved pin level
    output logic      [26:0] o_lvl
);
    timeunit 1ns;
    timeprecision 100ps;

    // a driven pin shows the block's value, a released one the far side's level
    assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

//--- bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rstn, wr, rd, als;
    logic [4:0]  addr;
    logic [7:0]  wd, d, v;
    logic [2:0]  r;
    logic [15:0] haddr, lat;
    logic [26:0] mc, cs, oet, ext;
    logic [5:0]  it;
    logic [7:0]  s_dout [4], s_dir [4], s_ctrl [4];
    wire  [26:0] lvl, pout, poe;
    wire  [23:0] ic;
    wire  [7:0]  rdat;
    int          n_mismatch, n_checks, cyc, p;

    cip_port dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_host_addr(haddr),
        .i_address_latch_strobe(als), .i_mcell(mc), .i_ext_cs(cs), .i_oe_term(oet),
        .i_icell_term(it), .o_icell(ic), .i_pin_a(lvl[7:0]), .o_pin_a(pout[7:0]),
        .o_pin_a_oe(poe[7:0]), .i_pin_b(lvl[15:8]), .o_pin_b(pout[15:8]), .o_pin_b_oe(poe[15:8]),
        .i_pin_c(lvl[23:16]), .o_pin_c(pout[23:16]), .o_pin_c_oe(poe[23:16]),
        .i_pin_d(lvl[26:24]), .o_pin_d(pout[26:24]), .o_pin_d_oe(poe[26:24]));
    cip_pins_model pins_u (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_lvl(lvl));

    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    function automatic logic [7:0] pb(input logic [26:0] x, input int q);
        return 8'(x >> (q * 8));
    endfunction
    function automatic logic [7:0] msk(input int q);
        return (q == 3) ? 8'h07 : 8'hff;
    endfunction
    // expected pin value: latched address where control is set, else data-out
    function automatic logic [7:0] pexp(input int q);
        return ((s_ctrl[q] & lat[7:0]) | (~s_ctrl[q] & s_dout[q])) & msk(q);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] x);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= x;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [4:0] a, output logic [7:0] x);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdat;
    endtask
    task automatic chk_pins;
        for (int q = 0; q < 4; q++)
        begin
            chk(pb(pout, q), pexp(q));
            chk(pb(poe, q), s_dir[q]);
            rreg({2'(q), cip_pkg::REG_DIN}, d);
            chk(d, ((s_dir[q] & pexp(q)) | (~s_dir[q] & pb(ext, q))) & msk(q));
            rreg({2'(q), cip_pkg::REG_DIR}, d);
            chk(d, s_dir[q]);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h1da5));
        {rstn, wr, rd, als, addr, wd, haddr, mc, cs, oet, it} = '0;
        ext = 27'h5a5a5a5;
        lat = 16'h0000;
        for (int q = 0; q < 4; q++)
            {s_dout[q], s_dir[q], s_ctrl[q]} = '0;
        repeat (10) @(posedge clk);
        chk({ic, rdat}, 32'h0);
        chk({5'h00, pout}, 32'h0);
        chk({5'h00, poe}, 32'h0);
        rstn <= 1'b1;
        // latch an address, then move the bus with the strobe low: latch must hold
        haddr <= 16'(($urandom));
        als <= 1'b1;
        repeat (8) @(posedge clk);
        lat = haddr;
        als <= 1'b0;
        repeat (8) @(posedge clk);
        haddr <= ~haddr;
        repeat (8) @(posedge clk);
        chk_pins();
        for (int i = 0; i < 40; i++)
        begin
            p = $urandom_range(3);
            r = 3'($urandom_range(1, 3));
            v = (i < 4) ? 8'hff : 8'($urandom);
            mc <= 27'($urandom);
            cs <= 27'($urandom);
            oet <= 27'($urandom);
            it <= 6'($urandom);
            ext <= 27'($urandom);
            wreg({2'(p), r}, v);
            if (r == cip_pkg::REG_DOUT)
                s_dout[p] = v & msk(p);
            else if (r == cip_pkg::REG_DIR)
                s_dir[p] = v & msk(p);
            else if (p < 2)
                s_ctrl[p] = v;
            rreg({2'(p), r}, d);
            chk(d, (r == 1) ? s_dout[p] : (r == 2) ? s_dir[p] : s_ctrl[p]);
            rreg({2'(p), cip_pkg::REG_MCELL}, d);
            chk(d, pb(mc, p) & msk(p));
            rreg({2'(p), 3'h6 + 3'(i & 1)}, d);
            chk(d, cip_pkg::RD_NONE);
            repeat (4) @(posedge clk);
            chk_pins();
            chk(ic, lvl[23:0]);
            rreg({2'(p), cip_pkg::REG_ICELL}, d);
            chk(d, (p < 3) ? pb(lvl, p) : 8'h00);
        end
        test_done();
    end
endmodule

//--- hdl/cip_pkg.sv
package cip_pkg;

    // pin counts: three 8-pin ports and one 3-pin port
    localparam int PORT_W  = 8;
    localparam int PIN_N   = 27;
    localparam int ICELL_N = 24;
    localparam int CTRL_N  = 16;
    localparam int ADDR_W  = 16;
    localparam int RADDR_W = 5;

    // register index inside a port, address = {port[1:0], reg[2:0]}
    localparam logic [2:0] REG_DIN   = 3'h0;
    localparam logic [2:0] REG_DOUT  = 3'h1;
    localparam logic [2:0] REG_DIR   = 3'h2;
    localparam logic [2:0] REG_CTRL  = 3'h3;
    localparam logic [2:0] REG_MCELL = 3'h4;
    localparam logic [2:0] REG_ICELL = 3'h5;

    // port numbers
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;

    // value read from an unmapped register
    localparam logic [7:0] RD_NONE = 8'h00;

    // whole state of the port block
    typedef struct packed {
        logic [PIN_N-1:0]   dout;
        logic [PIN_N-1:0]   dir;
        logic [CTRL_N-1:0]  ctrl;
        logic [PIN_N-1:0]   pin_s1;
        logic [PIN_N-1:0]   pin_s2;
        logic               ale_s1;
        logic               ale_s2;
        logic               ale_d;
        logic [ADDR_W-1:0]  adr_s1;
        logic [ADDR_W-1:0]  adr_s2;
        logic [ADDR_W-1:0]  lat_adr;
        logic [ICELL_N-1:0] icell;
        logic [5:0]         term_d;
        logic [PIN_N-1:0]   pin_out;
        logic [PIN_N-1:0]   pin_oe;
        logic [7:0]         rdata;
    } cip_state_s;

    // reset: all pins inputs, registers cleared
    localparam cip_state_s ST_RST = '0;

endpackage

//--- hdl/cip_port.sv
// Function
// - four ports: three eight pins, one three
// - every pin configured on its own
// - output source from configuration and control bits
// - sources: data-out, latched address, macrocell, chip-select
// - readback returns exactly one source per read
// - readback: data-out, macrocell, direction, control, pin
// - driver enabled by drive term OR direction
// - no term, not logic output: direction alone
// - host writes registers and reads them back
// - input cells: latch, edge register or pass
// - cell enable from address strobe or term
// - cell outputs feed logic and host readback
// - fixed modes set by programming, not runtime
// - other modes changed by host register writes
// - an assigned pin serves one function only
// - control bit zero selects host I/O mode
// - host I/O: drive data-out, read pin level
// - address out needs term or direction+control
module cip_port #(
    parameter logic [26:0] CFG_LOGIC_OUT  = 27'h0,  // pin driven by a macrocell
    parameter logic [26:0] CFG_EXT_CS     = 27'h0,  // pin driven by a chip-select
    parameter logic [26:0] CFG_OE_DEF     = 27'h0,  // pin has a drive-enable term
    parameter logic [23:0] ICELL_LATCH    = 24'h0,  // input cell is a latch
    parameter logic [23:0] ICELL_REG      = 24'h0,  // input cell is an edge register
    parameter logic [5:0]  ICELL_TERM_SEL = 6'h0,   // nibble enable from term, else strobe
    parameter logic        PORTB_ADR_HIGH = 1'b0    // port B drives address bits 15..8
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    // register port
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // host address bus and its strobe, asynchronous pins
    input  wire logic [15:0] i_host_addr,
    input  wire logic        i_address_latch_strobe,
    // logic array terms, same clock
    input  wire logic [26:0] i_mcell,
    input  wire logic [26:0] i_ext_cs,
    input  wire logic [26:0] i_oe_term,
    input  wire logic [5:0]  i_icell_term,
    // input cells towards the logic array
    output logic      [23:0] o_icell,
    // port pins
    input  wire logic [7:0]  i_pin_a,
    output logic      [7:0]  o_pin_a,
    output logic      [7:0]  o_pin_a_oe,
    input  wire logic [7:0]  i_pin_b,
    output logic      [7:0]  o_pin_b,
    output logic      [7:0]  o_pin_b_oe,
    input  wire logic [7:0]  i_pin_c,
    output logic      [7:0]  o_pin_c,
    output logic      [7:0]  o_pin_c_oe,
    input  wire logic [2:0]  i_pin_d,
    output logic      [2:0]  o_pin_d,
    output logic      [2:0]  o_pin_d_oe
);

    cip_pkg::cip_state_s st;
    cip_pkg::cip_state_s next_st;

    logic [1:0]  reg_port;
    logic [2:0]  reg_sel;
    logic [26:0] pins_in;
    logic [26:0] ctrl_ext;

    // picks one 8-bit port slice out of a flat pin vector
    function automatic logic [7:0] cip_slice(input logic [31:0] v, input logic [1:0] p);
        logic [31:0] s;
        s = v >> {p, 3'b000};
        return s[7:0];
    endfunction

    // address split and flattened pins
    assign reg_port = i_reg_addr[4:3];
    assign reg_sel  = i_reg_addr[2:0];
    assign pins_in  = {i_pin_d, i_pin_c, i_pin_b, i_pin_a};
    assign ctrl_ext = {11'h000, st.ctrl};  // ports C and D have no control bits

    // next-state logic of the whole block
    always_comb
    begin
        logic       wsel;
        logic       adrbit;
        logic       src;
        logic       en;
        logic       en_prev;
        logic       icin;
        logic [7:0] rd;
        wsel    = 1'b0;
        adrbit  = 1'b0;
        src     = 1'b0;
        en      = 1'b0;
        en_prev = 1'b0;
        icin    = 1'b0;
        rd      = cip_pkg::RD_NONE;
        next_st = st;

        // two-stage synchronisers for pins, address and strobe
        next_st.pin_s1 = pins_in;
        next_st.pin_s2 = st.pin_s1;
        next_st.adr_s1 = i_host_addr;
        next_st.adr_s2 = st.adr_s1;
        next_st.ale_s1 = i_address_latch_strobe;
        next_st.ale_s2 = st.ale_s1;
        next_st.ale_d  = st.ale_s2;
        next_st.term_d = i_icell_term;

        // address follows the bus while strobe is high, holds after
        if (st.ale_s2)
        begin
            next_st.lat_adr = st.adr_s2;
        end

        // per-pin register writes
        for (int i = 0; i < cip_pkg::PIN_N; i++)
        begin
            wsel = i_reg_wr && (reg_port == 2'(i / 8));
            if (wsel && reg_sel == cip_pkg::REG_DOUT)
            begin
                next_st.dout[i] = i_reg_wdata[i % 8];
            end
            if (wsel && reg_sel == cip_pkg::REG_DIR)
            begin
                next_st.dir[i] = i_reg_wdata[i % 8];
            end
            if (wsel && reg_sel == cip_pkg::REG_CTRL && i < cip_pkg::CTRL_N)
            begin
                next_st.ctrl[i] = i_reg_wdata[i % 8];
            end
        end

        // output source and driver enable per pin
        for (int i = 0; i < cip_pkg::PIN_N; i++)
        begin
            if (i >= 8 && i < 16 && PORTB_ADR_HIGH)
            begin
                adrbit = st.lat_adr[8 + (i % 8)];
            end
            else
            begin
                adrbit = st.lat_adr[i % 8];
            end
            // fixed functions take priority so a pin has one source
            if (CFG_LOGIC_OUT[i])
            begin
                src = i_mcell[i];
            end
            else if (CFG_EXT_CS[i])
            begin
                src = i_ext_cs[i];
            end
            else if (ctrl_ext[i])
            begin
                src = adrbit;
            end
            else
            begin
                src = st.dout[i];
            end
            next_st.pin_out[i] = src;
            // term OR direction; undefined-term logic outputs always drive
            next_st.pin_oe[i] = (CFG_OE_DEF[i] & i_oe_term[i]) | st.dir[i]
                              | (CFG_LOGIC_OUT[i] & ~CFG_OE_DEF[i]);
        end

        // input cells on ports A, B and C, one enable per nibble
        for (int i = 0; i < cip_pkg::ICELL_N; i++)
        begin
            en      = ICELL_TERM_SEL[i / 4] ? i_icell_term[i / 4] : st.ale_s2;
            en_prev = ICELL_TERM_SEL[i / 4] ? st.term_d[i / 4] : st.ale_d;
            icin    = st.pin_s2[i];
            if (ICELL_LATCH[i])
            begin
                next_st.icell[i] = en ? icin : st.icell[i];
            end
            else if (ICELL_REG[i])
            begin
                next_st.icell[i] = (en && !en_prev) ? icin : st.icell[i];
            end
            else
            begin
                next_st.icell[i] = icin;
            end
        end

        // readback selector: one source onto the data bus per read
        if (i_reg_rd)
        begin
            case (reg_sel)
                cip_pkg::REG_DIN:   rd = cip_slice({5'h00, st.pin_s2}, reg_port);
                cip_pkg::REG_DOUT:  rd = cip_slice({5'h00, st.dout}, reg_port);
                cip_pkg::REG_DIR:   rd = cip_slice({5'h00, st.dir}, reg_port);
                cip_pkg::REG_CTRL:  rd = cip_slice({16'h0000, st.ctrl}, reg_port);
                cip_pkg::REG_MCELL: rd = cip_slice({5'h00, i_mcell}, reg_port);
                cip_pkg::REG_ICELL: rd = cip_slice({8'h00, st.icell}, reg_port);
                default:            rd = cip_pkg::RD_NONE;
            endcase
        end
        next_st.rdata = rd;
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= cip_pkg::ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_reg_rdata = st.rdata;
    assign o_icell     = st.icell;
    assign o_pin_a     = st.pin_out[7:0];
    assign o_pin_a_oe  = st.pin_oe[7:0];
    assign o_pin_b     = st.pin_out[15:8];
    assign o_pin_b_oe  = st.pin_oe[15:8];
    assign o_pin_c     = st.pin_out[23:16];
    assign o_pin_c_oe  = st.pin_oe[23:16];
    assign o_pin_d     = st.pin_out[26:24];
    assign o_pin_d_oe  = st.pin_oe[26:24];

    // checks
    default clocking cip_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    drive_enable_a: assert property (
        ##1 {o_pin_d_oe, o_pin_c_oe, o_pin_b_oe, o_pin_a_oe}
            == $past((CFG_OE_DEF & i_oe_term) | st.dir | (CFG_LOGIC_OUT & ~CFG_OE_DEF)))
        else $error("driver enable differs from term or direction");

    dir_alone_a: assert property (
        (!CFG_OE_DEF[0] && !CFG_LOGIC_OUT[0]) |=> (o_pin_a_oe[0] == $past(st.dir[0])))
        else $error("pin a0 enable not set by direction alone");

    dout_write_a: assert property (
        (i_reg_wr && i_reg_addr == {cip_pkg::PORT_B, cip_pkg::REG_DOUT})
            |=> (st.dout[15:8] == $past(i_reg_wdata)))
        else $error("port b data-out write lost");

    readback_dir_a: assert property (
        (i_reg_rd && i_reg_addr == {cip_pkg::PORT_A, cip_pkg::REG_DIR})
            |=> (o_reg_rdata == $past(st.dir[7:0])))
        else $error("direction readback wrong");

    no_read_zero_a: assert property (
        !i_reg_rd |=> (o_reg_rdata == cip_pkg::RD_NONE))
        else $error("read data outside the read slot");

    ctrl_c_zero_a: assert property (
        (i_reg_rd && i_reg_addr == {cip_pkg::PORT_C, cip_pkg::REG_CTRL}) |=> (o_reg_rdata == 8'h00))
        else $error("port c control reads non-zero");

    addr_hold_a: assert property (
        !st.ale_s2 |=> $stable(st.lat_adr))
        else $error("latched address moved without strobe");

    addr_capture_a: assert property (
        st.ale_s2 |=> (st.lat_adr == $past(st.adr_s2)))
        else $error("address not captured during strobe");

    host_io_out_a: assert property (
        (!CFG_LOGIC_OUT[0] && !CFG_EXT_CS[0] && !st.ctrl[0]) |=> (o_pin_a[0] == $past(st.dout[0])))
        else $error("host I/O pin not driven from data-out");

    addr_out_a: assert property (
        (!CFG_LOGIC_OUT[1] && !CFG_EXT_CS[1] && st.ctrl[1] && st.dir[1])
            |=> (o_pin_a_oe[1] && o_pin_a[1] == $past(PORTB_ADR_HIGH ? st.lat_adr[1] : st.lat_adr[1])))
        else $error("address-out pin not driving latched address");

    icell_pass_a: assert property (
        (!ICELL_LATCH[0] && !ICELL_REG[0]) |=> (o_icell[0] == $past(st.pin_s2[0])))
        else $error("pass-through input cell lags");

    // a data-out write to port a lands in the register
    dout_a_write_a: assert property (
        (i_reg_wr && i_reg_addr == {cip_pkg::PORT_A, cip_pkg::REG_DOUT})
            |=> (st.dout[7:0] == $past(i_reg_wdata)))
        else $error("port a data-out write lost");

    // a direction write to port c lands in the register
    dir_c_write_a: assert property (
        (i_reg_wr && i_reg_addr == {cip_pkg::PORT_C, cip_pkg::REG_DIR})
            |=> (st.dir[23:16] == $past(i_reg_wdata)))
        else $error("port c direction write lost");

    // control bits of port b follow host writes at run time
    ctrl_b_write_a: assert property (
        (i_reg_wr && i_reg_addr == {cip_pkg::PORT_B, cip_pkg::REG_CTRL})
            |=> (st.ctrl[15:8] == $past(i_reg_wdata)))
        else $error("port b control write lost");

    // port d has three pins, upper data-out bits read zero
    dout_d_width_a: assert property (
        (i_reg_rd && i_reg_addr == {cip_pkg::PORT_D, cip_pkg::REG_DOUT})
            |=> (o_reg_rdata[7:3] == 5'h00))
        else $error("port d data-out reads phantom pins");

    // unmapped register slots put nothing on the bus
    unmapped_read_a: assert property (
        (i_reg_rd && reg_sel > cip_pkg::REG_ICELL)
            |=> (o_reg_rdata == cip_pkg::RD_NONE))
        else $error("unmapped register reads non-zero");

    // a logic output pin shows only its macrocell
    mcell_source_a: assert property (
        CFG_LOGIC_OUT[0]
            |=> (o_pin_a[0] == $past(i_mcell[0])))
        else $error("logic output pin not driven from macrocell");

    // a chip-select pin shows the chip-select source
    ext_cs_source_a: assert property (
        (!CFG_LOGIC_OUT[0] && CFG_EXT_CS[0])
            |=> (o_pin_a[0] == $past(i_ext_cs[0])))
        else $error("chip-select pin not driven from its source");

    // a logic output with no enable term always drives
    logic_drive_a: assert property (
        (CFG_LOGIC_OUT[0] && !CFG_OE_DEF[0])
            |=> o_pin_a_oe[0])
        else $error("logic output without term not driving");

    // a strobe-enabled latch follows the pin while open
    icell_latch_a: assert property (
        (ICELL_LATCH[0] && !ICELL_TERM_SEL[0] && st.ale_s2)
            |=> (o_icell[0] == $past(st.pin_s2[0])))
        else $error("open input latch not following pin");

    // an edge register holds between strobe rising edges
    icell_edge_a: assert property (
        (!ICELL_LATCH[0] && ICELL_REG[0] && !ICELL_TERM_SEL[0] && !(st.ale_s2 && !st.ale_d))
            |=> $stable(o_icell[0]))
        else $error("input register moved without strobe edge");

    // a term-enabled latch holds while its term is low
    icell_term_a: assert property (
        (ICELL_LATCH[0] && ICELL_TERM_SEL[0] && !i_icell_term[0])
            |=> $stable(o_icell[0]))
        else $error("input latch moved with its term low");

endmodule
